/* File: hw/sgp_pkg.sv */
// Package with register offsets, field layouts, mode codes and carriers for the serializer pin block.
package sgp_pkg;

  // Number of ports and number of configurable pins per port.
  localparam int SGP_PORTS = 2;
  localparam int SGP_PINS = 3;

  // Register offsets on the serial control bus.
  localparam logic [7:0] SGP_OFF_PIN0 = 8'h0d;
  localparam logic [7:0] SGP_OFF_PIN12 = 8'h0e;

  // Field positions inside the configuration registers.
  localparam int SGP_PIN0_LSB = 0;
  localparam int SGP_PIN1_LSB = 0;
  localparam int SGP_PIN2_LSB = 4;
  localparam int SGP_REV_LSB = 4;
  localparam int SGP_FIELD_W = 4;

  // Revision code shown in the upper nibble of the first register; the value is arbitrary.
  localparam logic [3:0] SGP_REV_CODE = 4'h1;

  // Reset value of every pin field (output value zero, mode zero).
  localparam logic [3:0] SGP_CFG_RST = 4'h0;

  // Read data for an offset that this block does not hold.
  localparam logic [7:0] SGP_RD_NONE = 8'h00;

  // Full mode codes.
  localparam logic [2:0] SGP_MODE_OUT = 3'h1;
  localparam logic [2:0] SGP_MODE_IN = 3'h3;
  localparam logic [2:0] SGP_MODE_RHOLD = 3'h5;
  localparam logic [2:0] SGP_MODE_RDEF = 3'h7;

  // Low two mode bits that pick the third pin's functional input and high impedance.
  localparam logic [1:0] SGP_MODE_FUNC_LO = 2'h0;
  localparam logic [1:0] SGP_MODE_HIZ_LO = 2'h2;

  // One pin's configuration field: output value above a three-bit mode.
  typedef struct packed {
    logic out_val;
    logic [2:0] mode;
  } sgp_pin_cfg_s;

  // One register access from the serial control bus engine.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sgp_reg_req_s;

endpackage : sgp_pkg

/* File: hw/sgp_pin.sv */
// One configurable pin: mode decode, remote hold latch and input synchroniser.
`timescale 1ns/1ns
module sgp_pin
  import sgp_pkg::*;
#(
  parameter bit HAS_FUNC = 1'b0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input sgp_pin_cfg_s cfg,
  input wire logic remote_val,
  input wire logic link_lost,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic func_sel,
  output logic in_val
);

  logic hold; // Last value received from the remote end while the link was up.
  logic sync1; // First synchroniser stage, read only by the second.
  logic sync2; // Second synchroniser stage.
  logic next_hold;
  logic next_sync1;
  logic next_sync2;
  logic is_local_out; // Pin is a plain local output.
  logic is_remote; // Pin is driven from the remote end.

  // Next values: the hold latch follows the remote value only while the link is up.
  always_comb begin
    next_hold = hold;
    next_sync1 = pin_i;
    next_sync2 = sync1;
    if (!link_lost) begin
      next_hold = remote_val;
    end
  end

  // Registers; clock enable low freezes everything.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hold <= 1'b0;
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else if (clk_en) begin
      hold <= next_hold;
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  // Mode decode straight from the registered field, so a write shows on the next cycle.
  always_comb begin
    is_local_out = (cfg.mode == SGP_MODE_OUT);
    is_remote = cfg.mode[0] && cfg.mode[2];
    pin_oe = is_local_out || is_remote;
    if (is_local_out) begin
      pin_o = cfg.out_val;
    end else if (is_remote && link_lost) begin
      // Hold mode keeps the last value, default mode falls back to the local bit.
      pin_o = cfg.mode[1] ? cfg.out_val : hold;
    end else if (is_remote) begin
      pin_o = remote_val;
    end else begin
      pin_o = 1'b0;
    end
    func_sel = HAS_FUNC && (cfg.mode[1:0] == SGP_MODE_FUNC_LO);
    in_val = (cfg.mode == SGP_MODE_IN) ? sync2 : 1'b0;
  end

endmodule : sgp_pin

/* File: hw/sgp_gpio_cfg.sv */
// Top of the pin configuration block: registers, port select and pin instances.
// What this block does
// - Local output drives the output-value bit.
// - Output-value bits reset to zero.
// - Mode 001 local output, 011 local input.
// - Pins 0,1: mode bit0 clear means high-impedance.
// - Pin 2: x00 functional input, x10 high-impedance.
// - Mode 101 remote value, hold on loss.
// - Mode 111 remote value, local bit on loss.
// - Second-port select redirects register reads and writes.
// - Link loss comes from the port's detector.
`timescale 1ns/1ns
module sgp_gpio_cfg
  import sgp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input sgp_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic second_port_select,
  input wire logic [SGP_PORTS-1:0] link_lost,
  input wire logic [SGP_PORTS-1:0][SGP_PINS-1:0] remote_val,
  input wire logic [SGP_PORTS-1:0][SGP_PINS-1:0] pin_i,
  output logic [SGP_PORTS-1:0][SGP_PINS-1:0] pin_o,
  output logic [SGP_PORTS-1:0][SGP_PINS-1:0] pin_oe,
  output logic [SGP_PORTS-1:0] func_sel,
  output logic [SGP_PORTS-1:0][SGP_PINS-1:0] in_val
);

  // Configuration fields for every pin of both ports.
  sgp_pin_cfg_s cfg [SGP_PORTS][SGP_PINS];
  sgp_pin_cfg_s next_cfg [SGP_PORTS][SGP_PINS];
  logic [7:0] next_rdata; // Read data to be registered.
  logic next_rvalid; // Read answer strobe to be registered.
  logic sel; // Port that register accesses address.

  // The select chooses the port that the access applies to.
  assign sel = second_port_select;

  // Next register values from a write to the selected port.
  always_comb begin
    next_cfg = cfg;
    if (reg_req.wr) begin
      if (reg_req.addr == SGP_OFF_PIN0) begin
        // Upper nibble holds the read-only revision, so only the low field is stored.
        next_cfg[sel][0] = reg_req.wdata[SGP_PIN0_LSB +: SGP_FIELD_W];
      end else if (reg_req.addr == SGP_OFF_PIN12) begin
        // Both pin fields of the shared register are written together.
        next_cfg[sel][1] = reg_req.wdata[SGP_PIN1_LSB +: SGP_FIELD_W];
        next_cfg[sel][2] = reg_req.wdata[SGP_PIN2_LSB +: SGP_FIELD_W];
      end
    end
  end

  // Next read answer, taken from the selected port.
  always_comb begin
    next_rvalid = reg_req.rd;
    next_rdata = reg_rdata;
    if (reg_req.rd) begin
      if (reg_req.addr == SGP_OFF_PIN0) begin
        next_rdata = {SGP_REV_CODE, cfg[sel][0]};
      end else if (reg_req.addr == SGP_OFF_PIN12) begin
        next_rdata = {cfg[sel][2], cfg[sel][1]};
      end else begin
        next_rdata = SGP_RD_NONE;
      end
    end
  end

  // Register stage for configuration and read answer; all fields clear at reset.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < SGP_PORTS; p++) begin
        for (int n = 0; n < SGP_PINS; n++) begin
          cfg[p][n] <= SGP_CFG_RST;
        end
      end
      reg_rdata <= SGP_RD_NONE;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      cfg <= next_cfg;
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // One pin instance for each pin of each port; only the third pin has a functional input.
  for (genvar gp = 0; gp < SGP_PORTS; gp++) begin : g_port
    logic [SGP_PINS-1:0] fsel; // Functional select of each pin; only the third can be set.
    for (genvar gn = 0; gn < SGP_PINS; gn++) begin : g_pin
      sgp_pin #(
        .HAS_FUNC(gn == SGP_PINS - 1)
      ) u_pin (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clk_en(clk_en),
        .cfg(cfg[gp][gn]),
        .remote_val(remote_val[gp][gn]),
        .link_lost(link_lost[gp]),
        .pin_i(pin_i[gp][gn]),
        .pin_o(pin_o[gp][gn]),
        .pin_oe(pin_oe[gp][gn]),
        .func_sel(fsel[gn]),
        .in_val(in_val[gp][gn])
      );
    end
    assign func_sel[gp] = fsel[SGP_PINS-1];
  end

  // Checks run on the system clock and sleep during reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Link drop while a pin sits in remote hold, after an enabled cycle with the link up.
  sequence s_hold_up;
    clk_en && !link_lost[0] && cfg[0][0].mode == SGP_MODE_RHOLD;
  endsequence
  sequence s_hold_drop;
    link_lost[0] && cfg[0][0].mode == SGP_MODE_RHOLD;
  endsequence

  // Local output mode drives the stored bit.
  a_local_out_drive: assert property (cfg[0][1].mode == SGP_MODE_OUT
    |-> pin_oe[0][1] && pin_o[0][1] == cfg[0][1].out_val)
    else $error("local output does not drive its value bit");

  // First cycle after reset release shows clear value bits and low pins on both ports.
  a_reset_clear: assert property ($rose(resetn)
    |-> cfg[1][2].out_val == 1'b0 && cfg[0][0].out_val == 1'b0 && pin_o[1] == '0 && pin_o[0] == '0)
    else $error("value bits not clear after reset");

  // Local input mode never drives and passes the synchronised pin two enabled edges later.
  a_input_path: assert property ((cfg[1][0].mode == SGP_MODE_IN && clk_en)[*3]
    |-> !pin_oe[1][0] && in_val[1][0] == $past(pin_i[1][0], 2))
    else $error("local input path wrong");

  // Even mode codes leave the first pin of the first port and the second pin of the second port floating.
  a_even_hiz: assert property ((cfg[0][0].mode[0] || !pin_oe[0][0])
    && (cfg[1][1].mode[0] || !pin_oe[1][1]))
    else $error("even mode code drives a pin");

  // Third pin: x00 selects the functional input, x10 floats without it.
  a_third_func: assert property (cfg[0][2].mode[0] == 1'b0 |-> !pin_oe[0][2]
    && func_sel[0] == (cfg[0][2].mode[1:0] == SGP_MODE_FUNC_LO))
    else $error("third pin functional select wrong");

  // Remote hold keeps the value received just before the link dropped.
  a_remote_hold: assert property (s_hold_up ##1 s_hold_drop
    |-> pin_oe[0][0] && pin_o[0][0] == $past(remote_val[0][0]))
    else $error("remote hold lost the last value");

  // Remote default falls back to the local bit on loss and follows the link otherwise.
  a_remote_default: assert property (cfg[0][1].mode == SGP_MODE_RDEF |-> pin_oe[0][1]
    && pin_o[0][1] == (link_lost[0] ? cfg[0][1].out_val : remote_val[0][1]))
    else $error("remote default output wrong");

  // A write with the select set lands in the second port and leaves the first alone.
  a_port_redirect: assert property (clk_en && reg_req.wr && second_port_select
    && reg_req.addr == SGP_OFF_PIN12
    |=> cfg[1][2] == $past(reg_req.wdata[SGP_PIN2_LSB +: SGP_FIELD_W]) && $stable(cfg[0][2]))
    else $error("select did not redirect the write");

  // A read answers one cycle later with the fields of the port selected at the access.
  a_port_read: assert property (clk_en && reg_req.rd && reg_req.addr == SGP_OFF_PIN12
    |=> reg_rvalid && reg_rdata == ($past(second_port_select) ? {$past(cfg[1][2]), $past(cfg[1][1])}
    : {$past(cfg[0][2]), $past(cfg[0][1])}))
    else $error("read answer wrong");

  // Writing local output mode shows on the pin in the next cycle.
  a_write_to_pin: assert property (clk_en && reg_req.wr && !second_port_select
    && reg_req.addr == SGP_OFF_PIN0 && reg_req.wdata[SGP_PIN0_LSB +: SGP_FIELD_W - 1] == SGP_MODE_OUT
    |=> pin_oe[0][0] && pin_o[0][0] == $past(reg_req.wdata[SGP_PIN0_LSB + SGP_FIELD_W - 1]))
    else $error("write did not reach pin next cycle");

endmodule : sgp_gpio_cfg

/* File: testbench/sgp_remote_model.sv */
// Model of the far-end deserializer: remote pin values and link state.
`timescale 1ns/1ns
module sgp_remote_model
  import sgp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [SGP_PORTS-1:0] drop,
  output logic [SGP_PORTS-1:0] link_lost,
  output logic [SGP_PORTS-1:0][SGP_PINS-1:0] remote_val
);
  // Values last sent per port while its link was up.
  logic [SGP_PORTS-1:0][SGP_PINS-1:0] sent;
  // Value that stood on each link at its last edge before the link dropped.
  logic [SGP_PORTS-1:0][SGP_PINS-1:0] last;

  // Sent values step every cycle while the link is up so that a stale copy shows.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sent <= '0;
      last <= '0;
    end else begin
      for (int p = 0; p < SGP_PORTS; p++) begin
        if (!drop[p]) begin
          sent[p] <= sent[p] + 3'h3;
          last[p] <= sent[p];
        end
      end
    end
  end

  // A lost link shows the inverse of what it carried last, so a pin that fails to hold is caught.
  always_comb begin
    link_lost = drop;
    for (int p = 0; p < SGP_PORTS; p++) begin
      remote_val[p] = drop[p] ? ~last[p] : sent[p];
    end
  end
endmodule : sgp_remote_model

/* File: testbench/sgp_gpio_cfg_tb.sv */
// Self-checking bench for the serializer pin configuration block.
`timescale 1ns/1ns
module sgp_gpio_cfg_tb
  import sgp_pkg::*;
;
  logic clk_sys, resetn, clk_en, second_port_select, reg_rvalid;
  sgp_reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic [1:0] drop, link_lost, func_sel;
  logic [1:0][2:0] remote_val, pin_i, pin_o, pin_oe, in_val;
  int miscompares, num_checks, cyc;
  logic [31:0] seed;
  logic [7:0] rd_q[$];  // Expected read data, oldest first.
  sgp_pin_cfg_s cfg_exp [SGP_PORTS][SGP_PINS];  // Expected fields per port and pin.

  sgp_gpio_cfg dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .second_port_select(second_port_select),
    .link_lost(link_lost), .remote_val(remote_val), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .func_sel(func_sel), .in_val(in_val));
  sgp_remote_model far (.clk_sys(clk_sys), .resetn(resetn), .drop(drop), .link_lost(link_lost),
    .remote_val(remote_val));

  // Free-running 50 MHz clock.
  always #10 clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected {drive enable, value, functional select, input level} of one pin.
  function automatic logic [3:0] pin_exp(input sgp_pin_cfg_s c, input logic r, input logic pi, input bit p2);
    logic [3:0] e;
    e = 4'h0;
    if (c.mode == SGP_MODE_OUT) e = {1'b1, c.out_val, 2'h0};
    else if (c.mode == SGP_MODE_RHOLD || c.mode == SGP_MODE_RDEF) e = {1'b1, r, 2'h0};
    else if (p2 && c.mode[1:0] == SGP_MODE_FUNC_LO) e = 4'h2;
    else if (c.mode == SGP_MODE_IN) e = {3'h0, pi};
    return e;
  endfunction : pin_exp

  task automatic cmp_rd(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_rd

  task automatic cmp_pin(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_pin

  // Compares every pin of both ports against the stored fields.
  task automatic chk_pins(input logic [1:0][2:0] rv);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 3; k++) begin
        cmp_pin("pin", pin_exp(cfg_exp[p][k], rv[p][k], pin_i[p][k], k == 2),
          {pin_oe[p][k], pin_o[p][k], k == 2 ? func_sel[p] : 1'b0, in_val[p][k]});
      end
    end
  endtask : chk_pins

  // One request held for one edge, then released.
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d, input logic en);
    @(posedge clk_sys);
    reg_req <= '{wr: w, rd: r, addr: a, wdata: d};
    clk_en <= en;
    @(posedge clk_sys);
    reg_req <= '0;
    clk_en <= 1'b1;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, d, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    acc(1'b0, 1'b1, a, 8'h00, 1'b1);
  endtask : rd

  task automatic report_and_stop;
    // A read that was never answered counts as a mismatch.
    if (rd_q.size() != 0) miscompares++;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // Each read answer is matched with the oldest expectation.
  always @(posedge clk_sys) begin
    if (reg_rvalid === 1'b1) begin
      if (rd_q.size() == 0) cmp_rd("unexpected rvalid", 8'h00, 8'hff);
      else cmp_rd("reg_rdata", rd_q.pop_front(), reg_rdata);
    end
  end

  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop;
    end
  end

  initial begin
    sgp_pin_cfg_s c;
    logic [1:0][2:0] rv;
    logic held;
    clk_sys = 1'b0;
    resetn = 1'b0;
    clk_en = 1'b1;
    reg_req = '0;
    second_port_select = 1'b0;
    drop = 2'h0;
    pin_i = '0;
    seed = 32'ha5fc5c1b;
    for (int p = 0; p < 2; p++) cfg_exp[p] = '{SGP_CFG_RST, SGP_CFG_RST, SGP_CFG_RST};
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    #1 chk_pins(remote_val);
    rd(SGP_OFF_PIN0, {SGP_REV_CODE, SGP_CFG_RST});
    rd(SGP_OFF_PIN12, 8'h00);
    rd(8'h20, SGP_RD_NONE);
    // Every mode and output value, on each port in turn.
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 8; m++) begin
        for (int v = 0; v < 2; v++) begin
          @(posedge clk_sys);
          pin_i <= seed[5:0];
          seed = lfsr(seed);
          second_port_select <= p[0];
          c.out_val = v[0];
          c.mode = m[2:0];
          wr(SGP_OFF_PIN0, {4'hf, c});
          wr(SGP_OFF_PIN12, {c, c});
          cfg_exp[p] = '{c, c, c};
          #1 chk_pins(remote_val);
          rd(SGP_OFF_PIN0, {SGP_REV_CODE, c});
          rd(SGP_OFF_PIN12, {c, c});
        end
      end
    end
    // A write while the clock enable is low leaves the field alone.
    acc(1'b1, 1'b0, SGP_OFF_PIN0, 8'h01, 1'b0);
    rd(SGP_OFF_PIN0, {SGP_REV_CODE, cfg_exp[1][0]});
    // Link loss under both remote modes on the first port.
    second_port_select <= 1'b0;
    wr(SGP_OFF_PIN0, {5'h00, SGP_MODE_RHOLD});
    wr(SGP_OFF_PIN12, {1'b0, SGP_MODE_RDEF, 1'b1, SGP_MODE_RDEF});
    cfg_exp[0] = '{'{1'b0, SGP_MODE_RHOLD}, '{1'b1, SGP_MODE_RDEF}, '{1'b0, SGP_MODE_RDEF}};
    @(negedge clk_sys);
    held = remote_val[0][0];
    @(posedge clk_sys);
    drop <= 2'h3;
    repeat (3) @(posedge clk_sys);
    #1 rv = remote_val;
    rv[0] = {1'b0, 1'b1, held};
    // The second port sits in remote default with every value bit set.
    rv[1] = 3'h7;
    chk_pins(rv);
    @(posedge clk_sys);
    drop <= 2'h0;
    // A reset in mid-run clears the value bits that were written above.
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int p = 0; p < 2; p++) cfg_exp[p] = '{SGP_CFG_RST, SGP_CFG_RST, SGP_CFG_RST};
    #1 chk_pins(remote_val);
    rd(SGP_OFF_PIN0, {SGP_REV_CODE, SGP_CFG_RST});
    second_port_select <= 1'b1;
    rd(SGP_OFF_PIN12, 8'h00);
    repeat (3) @(posedge clk_sys);
    report_and_stop;
  end
endmodule : sgp_gpio_cfg_tb
